// File: test/bbm_flash_model.sv
/*
  Behavioural flash behind the command engine: bad marks, status and ECC feature bytes.
  Assumes one request at a time from the bad-block manager on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module bbm_flash_model
  import bbm_pkg::*;
#(
  parameter logic [BLK_W-1:0] BAD_A = 11'h005,
  parameter logic [BLK_W-1:0] BAD_B = 11'h7ff
)(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic flash_req,
  input wire bbm_op_type flash_op,
  input wire logic [BLK_W-1:0] flash_block,
  input wire logic [7:0] flash_feat,
  input wire logic [3:0] latency,
  input wire logic fail_en,
  input wire logic [BLK_W-1:0] fail_blk,
  input wire logic [3:0] mbf_val,
  output logic flash_done,
  output logic [7:0] flash_rdata,
  output logic [7:0] busy_viol
);
  logic pend;
  logic [3:0] wait_cnt;
  bbm_op_type op_q;
  logic [BLK_W-1:0] blk_q;
  logic [7:0] feat_q, status, ecc_feat, noise;
  logic factory_bad, hit_bad;
  assign factory_bad = blk_q == BAD_A || blk_q == BAD_B;
  assign hit_bad = factory_bad || (fail_en && blk_q == fail_blk);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend <= 1'b0;
      wait_cnt <= 4'h0;
      op_q <= OP_MARK_RD;
      blk_q <= '0;
      feat_q <= 8'h00;
      status <= 8'h00;
      ecc_feat <= 8'h00;
      noise <= 8'h5a;
      flash_done <= 1'b0;
      flash_rdata <= 8'h00;
      busy_viol <= 8'h00;
    end else begin
      flash_done <= 1'b0;
      noise <= noise + 8'h3b;
      // Idle data changes every cycle so a stale byte is never mistaken for an answer
      flash_rdata <= ~noise;
      if (flash_req) begin
        busy_viol <= busy_viol + {7'h00, pend};
        pend <= 1'b1;
        wait_cnt <= latency;
        op_q <= flash_op;
        blk_q <= flash_block;
        feat_q <= flash_feat;
      end else if (pend && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (pend) begin
        pend <= 1'b0;
        flash_done <= 1'b1;
        case (op_q)
          OP_MARK_RD: flash_rdata <= factory_bad ? MARK_BAD : 8'hff;
          OP_PAGE_RD: ecc_feat <= {mbf_val, 4'h0};
          OP_ERASE: status <= (8'(hit_bad) << ST_EFAIL_BIT) | (8'h01 << ST_BUSY_BIT);
          OP_PROGRAM, OP_PROTECT: status <= (8'(hit_bad) << ST_PFAIL_BIT) | (8'h01 << ST_BUSY_BIT);
          default: begin
            flash_rdata <= feat_q == FEAT_STATUS ? status :
                           feat_q == FEAT_ECC ? ecc_feat : 8'h00;
            // busy on the first poll only, so the host must poll again
            if (feat_q == FEAT_STATUS) begin
              status[ST_BUSY_BIT] <= 1'b0;
            end
          end
        endcase
      end
    end
  end
endmodule : bbm_flash_model
`default_nettype wire

// File: test/bbm_top_tb.sv
/*
  Register-level bench of the bad-block manager with a flash model behind it.
  Assumes the register map of the package and a single 250 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module bbm_top_tb
  import bbm_pkg::*;
;
  logic clock, rst_b, bus_wr, bus_rd, flash_req, flash_done, irq, fail_en;
  logic [7:0] bus_addr, flash_feat, pad_byte, flash_rdata, busy_viol;
  logic [31:0] bus_wdata, bus_rdata, d;
  bbm_op_type flash_op;
  logic [BLK_W-1:0] flash_block, fail_blk, alt_blk, spare, b;
  logic [3:0] latency, mbf_val, m;
  logic [NUM_BLOCKS-1:0] bad_exp;
  logic [11:0] exp_bad;
  int n_fail, cmp_count, cycles, i;
  bbm_op_type ops [3] = '{OP_PROGRAM, OP_ERASE, OP_PROTECT};
  logic [3:0] mv [5] = '{4'h0, 4'h5, 4'h6, 4'h8, 4'hf};

  bbm_top bbm_top_i (.clock, .rst_b, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .irq,
    .flash_req, .flash_op, .flash_block, .flash_feat, .pad_byte, .flash_done, .flash_rdata);
  bbm_flash_model bbm_flash_model_i (.clock, .rst_b, .flash_req, .flash_op, .flash_block,
    .flash_feat, .latency, .fail_en, .fail_blk, .mbf_val, .flash_done, .flash_rdata, .busy_viol);

  task automatic final_report;
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge clock);
    bus_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : rd

  // Start one command, wait until idle, check and clear the events it raised
  task automatic run_op(input bbm_op_type op, input logic [BLK_W-1:0] blk, input logic [6:0] ev);
    int k;
    wr(REG_CTRL, {5'h00, blk, 12'h000, op, 1'b1});
    repeat (3) @(posedge clock);
    k = 0;
    d = 32'h1;
    while (d[0] !== 1'b0 && k < 500) begin
      rd(REG_STATUS);
      k++;
    end
    `CHK(d[0], 1'b0)
    rd(REG_INT_STAT);
    `CHK(d[6:0], ev)
    wr(REG_INT_STAT, 32'h7f);
  endtask : run_op

  task automatic bbt(input logic [BLK_W-1:0] blk, input logic exp);
    wr(REG_BBT, {21'h0, blk});
    rd(REG_BBT);
    `CHK(d[31], exp)
  endtask : bbt

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Every alter command must target a block still believed good
  always @(posedge clock) begin
    if (flash_req && (flash_op == OP_PROGRAM || flash_op == OP_ERASE
                      || flash_op == OP_PROTECT)) begin
      alt_blk <= flash_block;
      `CHK(bad_exp[flash_block], 1'b0)
    end
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    rst_b = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    latency = 4'h0;
    fail_en = 1'b0;
    fail_blk = '0;
    mbf_val = 4'h0;
    n_fail = 0;
    cmp_count = 0;
    cycles = 0;
    bad_exp = '0;
    bad_exp[5] = 1'b1;
    bad_exp[2047] = 1'b1;
    exp_bad = 12'h002;
    repeat (8) @(posedge clock);
    `CHK(pad_byte, 8'hff)
    rst_b <= 1'b1;
    @(posedge clock);
    #1;
    `CHK({flash_req, flash_block, flash_op}, {1'b1, 11'h000, OP_MARK_RD})
    wr(REG_CTRL, {5'h00, 11'h00a, 12'h000, OP_ERASE, 1'b1});
    d = 32'h0;
    i = 0;
    while (d[1] !== 1'b1 && i < 6000) begin
      rd(REG_STATUS);
      i++;
    end
    `CHK(d[1], 1'b1)
    `CHK(d[27:16], exp_bad)
    rd(REG_INT_STAT);
    `CHK(d[6:0], 7'h20)
    bbt(11'h005, 1'b1);
    bbt(11'h006, 1'b0);
    bbt(11'h7ff, 1'b1);
    wr(REG_INT_MASK, 32'h0);
    `CHK(irq, 1'b0)
    wr(REG_INT_MASK, 32'h7f);
    `CHK(irq, 1'b1)
    wr(REG_INT_STAT, 32'h20);
    `CHK(irq, 1'b0)
    wr(8'h40, 32'hffffffff);
    rd(8'h40);
    `CHK(d, 32'h0)
    rd(REG_ECC_LIMIT);
    `CHK(d[3:0], ECC_LIMIT_RST)
    latency <= 4'h3;
    for (i = 0; i < 3; i++) begin
      run_op(ops[i], 11'h005, 7'h02);
      run_op(ops[i], 11'h7ff, 7'h02);
    end
    run_op(OP_ERASE, 11'h00a, 7'h01);
    `CHK(alt_blk, 11'h00a)
    for (i = 0; i < 3; i++) begin
      b = 11'(20 + 10 * i);
      fail_blk <= b;
      fail_en <= 1'b1;
      run_op(ops[i], b, 7'h05);
      exp_bad++;
      bad_exp[b] = 1'b1;
      rd(REG_SPARE);
      spare = d[10:0];
      `CHK(alt_blk, spare)
      `CHK({bad_exp[spare], spare == b}, 2'b00)
      rd(REG_STATUS);
      `CHK(d[27:16], exp_bad)
      run_op(ops[i], b, 7'h02);
    end
    fail_en <= 1'b0;
    for (i = 0; i < 5; i++) begin
      m = mv[i];
      mbf_val <= m;
      run_op(OP_PAGE_RD, 11'h00a,
        {2'b00, m > 4'h8, m >= ECC_LIMIT_RST && m <= 4'h8, 3'b001});
      rd(REG_STATUS);
      `CHK(d[11:8], m)
      `CHK(d[27:16], exp_bad)
    end
    `CHK(busy_viol, 8'h00)
    final_report();
  end
endmodule : bbm_top_tb
`default_nettype wire

// File: verilog/bbm_pkg.sv
/*
  Constants, register map and operation codes of the flash bad-block manager.
  Assumes a flash command engine on the same clock that runs one operation per request.
*/
`default_nettype none
package bbm_pkg;
  localparam int NUM_BLOCKS = 2048;
  localparam int BLK_W = 11;
  localparam logic [BLK_W-1:0] BLK_LAST = 11'h7ff;
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0c;
  localparam logic [7:0] REG_BBT = 8'h10;
  localparam logic [7:0] REG_SPARE = 8'h14;
  localparam logic [7:0] REG_ECC_LIMIT = 8'h18;
  // Control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_RESCAN = 4;
  localparam int CTRL_BLK_LSB = 16;
  // Interrupt events
  localparam int NUM_EV = 7;
  localparam int EV_DONE = 0;
  localparam int EV_REJECT = 1;
  localparam int EV_RETIRE = 2;
  localparam int EV_REWRITE = 3;
  localparam int EV_UNCORR = 4;
  localparam int EV_SCAN = 5;
  localparam int EV_NOSPARE = 6;
  // Flash feature table
  localparam logic [7:0] FEAT_STATUS = 8'hc0;
  localparam logic [7:0] FEAT_ECC = 8'h30;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_EFAIL_BIT = 2;
  localparam int ST_PFAIL_BIT = 3;
  localparam int MBF_LSB = 4;
  localparam logic [3:0] MBF_CORR_MAX = 4'h8;
  localparam logic [3:0] ECC_LIMIT_RST = 4'h6;
  localparam logic [7:0] MARK_BAD = 8'h00;
  localparam logic [7:0] PAD_FILL = 8'hff;

  typedef enum logic [2:0] {
    OP_MARK_RD, OP_PAGE_RD, OP_PROGRAM, OP_ERASE, OP_PROTECT, OP_GET_FEAT
  } bbm_op_type;

  function automatic logic bbm_alters(input bbm_op_type op);
    return op == OP_PROGRAM || op == OP_ERASE || op == OP_PROTECT;
  endfunction : bbm_alters
endpackage : bbm_pkg
`default_nettype wire

// File: verilog/bbm_top.sv
/*
  Host-side bad-block manager: scans factory marks, guards and checks block operations,
  retires failing blocks onto spares and watches the read ECC report.
  Assumes a command engine on clock that answers each flash_req with one flash_done pulse.
*/
// The register addresses and strobed register access were decided locally.
// Operation
// R1 - Flash refuses program or erase on factory bad blocks, flagging a failure.
// R2 - Never program, protect or erase a block known to be bad.
// R3 - Scan reads one marker byte per block; zero means bad.
// R4 - Bad-block scan runs after installation, before any normal operation.
// R5 - Blocks found bad by the scan are excluded from all later accesses.
// R6 - Never erase a detected bad block, keeping its marking intact.
// R7 - After erase, read status; on failure retire and replace the block.
// R8 - After protect, check program fail flag; on failure replace the block.
// R9 - On program failure rewrite data into a good block, bar the old one.
// R10 - Erase failures go into the bad-block table, never accessed again; a rescan refills every entry from its marker byte and drops them.
// R11 - After reads fetch ECC status and flag rewrite before uncorrectable errors.
// R12 - Retire blocks only on program or erase status failures, not bit errors.
// R13 - Correct up to eight bits per 512 bytes; more is uncorrectable.
// R14 - Spread wear across blocks rather than concentrating on a few.
// R15 - Pad unused page areas with ones, never zeros.
// R16 - While flash is busy, send only feature reads or reset.
// R17 - Flash reports the worst sector bit-flip count at feature 30h.
// R18 - Keep one bad bit per block, filled by scan, checked before commands.
`timescale 1ns/100ps
`default_nettype none
module bbm_top
  import bbm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output logic irq,
  output logic flash_req,
  output bbm_op_type flash_op,
  output logic [BLK_W-1:0] flash_block,
  output logic [7:0] flash_feat,
  output logic [7:0] pad_byte,
  input wire logic flash_done,
  input wire logic [7:0] flash_rdata
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_SCAN_REQ, ST_SCAN_WAIT, ST_CHECK, ST_OP_REQ, ST_OP_WAIT,
    ST_POLL_REQ, ST_POLL_WAIT, ST_ECC_REQ, ST_ECC_WAIT, ST_FIND_SPARE
  } bbm_state_type;

  bbm_state_type state, next_state;
  bbm_op_type cur_op, next_cur_op, next_flash_op;
  logic [BLK_W-1:0] cur_blk, next_cur_blk, scan_idx, next_scan_idx, rover, next_rover;
  logic [BLK_W-1:0] tries, next_tries, spare_blk, next_spare_blk, bbt_ptr, next_bbt_ptr;
  logic [BLK_W-1:0] next_flash_block, bad_waddr;
  logic [11:0] bad_count, next_bad_count;
  logic [3:0] max_bitflip_count, next_mbf, ecc_limit, next_ecc_limit;
  logic [NUM_EV-1:0] int_stat, next_int_stat, int_mask, next_int_mask, ev;
  logic [7:0] next_flash_feat;
  logic [31:0] next_bus_rdata;
  logic scan_done, next_scan_done, scan_pend, next_scan_pend, bad_we, bad_wval, busy, fail;
  logic wr_ctrl, start_cmd;
  bbm_op_type cmd_op;
  logic bad_tab [NUM_BLOCKS];

  assign busy = state != ST_IDLE || scan_pend;
  assign wr_ctrl = bus_wr && bus_addr == REG_CTRL;
  assign cmd_op = bbm_op_type'(bus_wdata[CTRL_OP_LSB +: 3]);
  assign start_cmd = wr_ctrl && bus_wdata[CTRL_START] && !bus_wdata[CTRL_RESCAN]
                     && (cmd_op == OP_PAGE_RD || bbm_alters(cmd_op));
  assign flash_req = state == ST_SCAN_REQ || state == ST_OP_REQ
                     || state == ST_POLL_REQ || state == ST_ECC_REQ;
  // R8 protect reports through the program fail flag
  assign fail = cur_op == OP_ERASE ? flash_rdata[ST_EFAIL_BIT] : flash_rdata[ST_PFAIL_BIT];
  assign irq = |(int_stat & int_mask);
  // R15 pad with ones
  assign pad_byte = PAD_FILL;

  always_comb begin
    next_state = state;
    next_cur_op = cur_op;
    next_cur_blk = cur_blk;
    next_scan_idx = scan_idx;
    next_rover = rover;
    next_tries = tries;
    next_spare_blk = spare_blk;
    next_bad_count = bad_count;
    next_mbf = max_bitflip_count;
    next_scan_done = scan_done;
    next_scan_pend = scan_pend;
    next_flash_op = flash_op;
    next_flash_block = flash_block;
    next_flash_feat = flash_feat;
    ev = '0;
    bad_we = 1'b0;
    bad_wval = 1'b0;
    bad_waddr = cur_blk;
    unique case (state)
      ST_IDLE: begin
        // R4 scan before normal use
        if (scan_pend) begin
          next_scan_pend = 1'b0;
          next_scan_done = 1'b0;
          next_scan_idx = '0;
          next_bad_count = '0;
          next_flash_op = OP_MARK_RD;
          next_flash_block = '0;
          next_state = ST_SCAN_REQ;
        end else if (start_cmd) begin
          next_cur_op = cmd_op;
          next_cur_blk = bus_wdata[CTRL_BLK_LSB +: BLK_W];
          next_state = ST_CHECK;
        end
      end
      ST_SCAN_REQ: next_state = ST_SCAN_WAIT;
      ST_SCAN_WAIT: begin
        if (flash_done) begin
          // R3 zero marker means bad
          bad_we = 1'b1;
          bad_waddr = scan_idx;
          bad_wval = flash_rdata == MARK_BAD;
          if (bad_wval) begin
            next_bad_count = bad_count + 1'b1;
          end
          if (scan_idx == BLK_LAST) begin
            next_scan_done = 1'b1;
            ev[EV_SCAN] = 1'b1;
            next_state = ST_IDLE;
          end else begin
            next_scan_idx = scan_idx + 1'b1;
            next_flash_block = scan_idx + 1'b1;
            next_state = ST_SCAN_REQ;
          end
        end
      end
      ST_CHECK: begin
        // R2 R5 R6 R18 table checked first
        if (!scan_done || bad_tab[cur_blk]) begin
          ev[EV_REJECT] = 1'b1;
          next_state = ST_IDLE;
        end else begin
          next_flash_op = cur_op;
          next_flash_block = cur_blk;
          next_state = ST_OP_REQ;
        end
      end
      ST_OP_REQ: next_state = ST_OP_WAIT;
      ST_OP_WAIT: begin
        if (flash_done) begin
          next_flash_op = OP_GET_FEAT;
          next_flash_feat = FEAT_STATUS;
          next_state = ST_POLL_REQ;
        end
      end
      ST_POLL_REQ: next_state = ST_POLL_WAIT;
      ST_POLL_WAIT: begin
        if (flash_done) begin
          // R16 only feature reads while busy
          if (flash_rdata[ST_BUSY_BIT]) begin
            next_state = ST_POLL_REQ;
          end else if (cur_op == OP_PAGE_RD) begin
            // R11 R17 fetch bit-flip report
            next_flash_feat = FEAT_ECC;
            next_state = ST_ECC_REQ;
          end else if (fail) begin
            // R7 R8 R9 R10 retire failing block
            bad_we = 1'b1;
            bad_wval = 1'b1;
            next_bad_count = bad_count + 1'b1;
            ev[EV_RETIRE] = 1'b1;
            next_tries = '0;
            next_state = ST_FIND_SPARE;
          end else begin
            ev[EV_DONE] = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      ST_ECC_REQ: next_state = ST_ECC_WAIT;
      ST_ECC_WAIT: begin
        if (flash_done) begin
          // R12 bit errors never retire a block
          next_mbf = flash_rdata[MBF_LSB +: 4];
          // R13 beyond eight bits is lost
          if (next_mbf > MBF_CORR_MAX) begin
            ev[EV_UNCORR] = 1'b1;
          end else if (next_mbf >= ecc_limit) begin
            ev[EV_REWRITE] = 1'b1;
          end
          ev[EV_DONE] = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_FIND_SPARE: begin
        // R14 rotating spare pointer spreads wear
        next_rover = rover + 1'b1;
        if (!bad_tab[rover]) begin
          // R9 redo the operation on the spare
          next_spare_blk = rover;
          next_cur_blk = rover;
          next_flash_op = cur_op;
          next_flash_block = rover;
          next_state = ST_OP_REQ;
        end else if (tries == BLK_LAST) begin
          ev[EV_NOSPARE] = 1'b1;
          next_state = ST_IDLE;
        end else begin
          next_tries = tries + 1'b1;
        end
      end
    endcase
    if (wr_ctrl && bus_wdata[CTRL_RESCAN] && state == ST_IDLE && !scan_pend) begin
      next_scan_pend = 1'b1;
    end
  end

  always_comb begin
    next_int_stat = int_stat | ev;
    next_int_mask = int_mask;
    next_ecc_limit = ecc_limit;
    next_bbt_ptr = bbt_ptr;
    next_bus_rdata = '0;
    if (bus_wr) begin
      unique case (bus_addr)
        REG_INT_STAT: next_int_stat = (int_stat & ~bus_wdata[NUM_EV-1:0]) | ev;
        REG_INT_MASK: next_int_mask = bus_wdata[NUM_EV-1:0];
        REG_BBT: next_bbt_ptr = bus_wdata[BLK_W-1:0];
        REG_ECC_LIMIT: next_ecc_limit = bus_wdata[3:0];
        default: ;
      endcase
    end
    if (bus_rd) begin
      unique case (bus_addr)
        REG_CTRL: next_bus_rdata = {5'h0, cur_blk, 12'h0, cur_op, 1'b0};
        REG_STATUS: next_bus_rdata = {4'h0, bad_count, 4'h0, max_bitflip_count, 6'h0, scan_done, busy};
        REG_INT_STAT: next_bus_rdata = {25'h0, int_stat};
        REG_INT_MASK: next_bus_rdata = {25'h0, int_mask};
        REG_BBT: next_bus_rdata = {bad_tab[bbt_ptr], 20'h0, bbt_ptr};
        REG_SPARE: next_bus_rdata = {21'h0, spare_blk};
        REG_ECC_LIMIT: next_bus_rdata = {28'h0, ecc_limit};
        default: next_bus_rdata = '0;
      endcase
    end
  end

  // Table has no reset; the scan rewrites every entry before use
  always_ff @(posedge clock) begin
    if (bad_we) begin
      bad_tab[bad_waddr] <= bad_wval;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      cur_op <= OP_PAGE_RD;
      cur_blk <= '0;
      scan_idx <= '0;
      rover <= '0;
      tries <= '0;
      spare_blk <= '0;
      bad_count <= '0;
      max_bitflip_count <= '0;
      scan_done <= 1'b0;
      scan_pend <= 1'b1;
      flash_op <= OP_MARK_RD;
      flash_block <= '0;
      flash_feat <= '0;
      int_stat <= '0;
      int_mask <= '0;
      ecc_limit <= ECC_LIMIT_RST;
      bbt_ptr <= '0;
      bus_rdata <= '0;
    end else begin
      state <= next_state;
      cur_op <= next_cur_op;
      cur_blk <= next_cur_blk;
      scan_idx <= next_scan_idx;
      rover <= next_rover;
      tries <= next_tries;
      spare_blk <= next_spare_blk;
      bad_count <= next_bad_count;
      max_bitflip_count <= next_mbf;
      scan_done <= next_scan_done;
      scan_pend <= next_scan_pend;
      flash_op <= next_flash_op;
      flash_block <= next_flash_block;
      flash_feat <= next_flash_feat;
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
      ecc_limit <= next_ecc_limit;
      bbt_ptr <= next_bbt_ptr;
      bus_rdata <= next_bus_rdata;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  AST_NO_BAD_ALTER: assert property ( // R2
    flash_req && bbm_alters(flash_op) |-> !bad_tab[flash_block])
    else $error("altering operation sent to a bad block");
  AST_SCAN_FIRST: assert property ( // R4
    flash_req && flash_op != OP_MARK_RD |-> scan_done)
    else $error("operation before scan finished");
  AST_MARK_COUNT: assert property ( // R3
    state == ST_SCAN_WAIT && flash_done && flash_rdata == MARK_BAD
    |=> bad_count == $past(bad_count) + 12'h1 && bad_tab[$past(scan_idx)])
    else $error("zero marker not recorded");
  AST_BUSY_POLL: assert property ( // R16
    state == ST_POLL_WAIT && flash_done && flash_rdata[ST_BUSY_BIT]
    |=> flash_req && flash_op == OP_GET_FEAT ##1 !flash_req)
    else $error("busy flash not polled by feature read");
  AST_ERASE_RETIRE: assert property ( // R7
    state == ST_POLL_WAIT && flash_done && !flash_rdata[ST_BUSY_BIT]
    && cur_op == OP_ERASE && flash_rdata[ST_EFAIL_BIT]
    |=> bad_tab[$past(cur_blk)] && int_stat[EV_RETIRE] && state == ST_FIND_SPARE)
    else $error("erase failure not retired");
  AST_PROTECT_RETIRE: assert property ( // R8
    state == ST_POLL_WAIT && flash_done && !flash_rdata[ST_BUSY_BIT]
    && cur_op == OP_PROTECT && flash_rdata[ST_PFAIL_BIT] |=> bad_tab[$past(cur_blk)])
    else $error("protect failure not retired");
  AST_PROG_REDO: assert property ( // R9
    state == ST_FIND_SPARE && !bad_tab[rover] && cur_op == OP_PROGRAM
    |=> flash_req && flash_op == OP_PROGRAM && flash_block == $past(rover))
    else $error("program not redone on spare");
  AST_ECC_FETCH: assert property ( // R11
    state == ST_POLL_WAIT && flash_done && !flash_rdata[ST_BUSY_BIT] && cur_op == OP_PAGE_RD
    |=> flash_req && flash_op == OP_GET_FEAT && flash_feat == FEAT_ECC)
    else $error("ECC report not fetched after read");
  AST_ECC_NO_RETIRE: assert property ( // R12
    state == ST_ECC_WAIT |-> !bad_we)
    else $error("block retired on bit errors");
  AST_UNCORR: assert property ( // R13
    state == ST_ECC_WAIT && flash_done && flash_rdata[MBF_LSB +: 4] > MBF_CORR_MAX
    |=> int_stat[EV_UNCORR] && (irq || !int_mask[EV_UNCORR]))
    else $error("uncorrectable read not flagged");

  COV_SCAN: cover property (state == ST_SCAN_WAIT && flash_done && scan_idx == BLK_LAST);
  COV_RETIRE: cover property (state == ST_FIND_SPARE ##1 state == ST_OP_REQ);
  COV_REWRITE: cover property (ev[EV_REWRITE]);
  COV_REJECT: cover property (ev[EV_REJECT] && scan_done);
endmodule : bbm_top
`default_nettype wire
